// >>> imd_unit.v
// integer multiply/divide unit with nibble-wide i/o registers
`timescale 1ns/1ps
`include "imd_defs.vh"
//////////////////////////////////////////////////////////////////////////////
module imd_unit #(
    parameter DIV_STEPS = 16
) (
    // clock and reset
    input wire CLOCK_I,
    input wire RST_I,
    // oscillator ticks and cpu clock selection
    input wire LOW_OSC_TICK_I,
    input wire HIGH_OSC_TICK_I,
    input wire HIGH_OSC_ON_I,
    input wire CPU_CLOCK_SWITCH_I,
    // cpu i/o bus
    input wire [15:0] ADDR_I,
    input wire [3:0] WDATA_I,
    input wire WR_I,
    input wire RD_I,
    output reg [3:0] RDATA_O,
    // status
    output reg BUSY_O
);
    reg [3:0] clk_gates;
    reg [7:0] source_operand;
    reg [7:0] dest_low_byte;
    reg [7:0] dest_high_byte;
    reg negative_flag;
    reg overflow_flag;
    reg zero_result_flag;
    reg calc_mode_bit;
    reg op_mode;
    reg [3:0] cyc_cnt;
    reg [15:0] op_dest;
    reg [7:0] op_src;
    reg [15:0] next_product;
    reg div_load;
    reg [4:0] step_cnt;
    wire tick;
    wire arith_clock_enable;
    wire [15:0] quotient;
    wire [8:0] remainder;
    wire start;
    wire wr_en;
    wire finish;
    wire div_ovf;

    assign arith_clock_enable = clk_gates[`IMD_BIT_ARITH_CKE];
    assign wr_en = WR_I && tick;
    assign start = wr_en && (ADDR_I == `IMD_ADDR_CTRL) && !calc_mode_bit;
    assign finish = calc_mode_bit && tick &&
        (cyc_cnt == `IMD_OP_CYCLES - 4'h1);
    // overflow when high byte not below divisor, includes divisor zero
    assign div_ovf = (op_dest[15:8] >= op_src);

    //////////////////////////////////////////////////////////////////////////
    imd_clock_select u_clk (
        .clk_i(CLOCK_I),
        .rst_i(RST_I),
        .low_osc_tick_i(LOW_OSC_TICK_I),
        .high_osc_tick_i(HIGH_OSC_TICK_I),
        .high_osc_on_i(HIGH_OSC_ON_I),
        .cpu_clock_switch_i(CPU_CLOCK_SWITCH_I),
        .arith_clock_enable_i(arith_clock_enable),
        .tick_o(tick)
    );

    imd_divider u_div (
        .clk_i(CLOCK_I),
        .rst_i(RST_I),
        .load_i(div_load),
        .step_i(calc_mode_bit && (step_cnt != 5'h00)),
        .dividend_i(op_dest),
        .divisor_i(op_src),
        .quotient_o(quotient),
        .remainder_o(remainder)
    );

    //////////////////////////////////////////////////////////////////////////
    // clock gate register is written on the fast clock, always accessible
    always @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            clk_gates <= `IMD_GATES_RESET;
        end else if (WR_I && ADDR_I == `IMD_ADDR_CLK_GATES) begin
            clk_gates <= WDATA_I;
        end
    end

    // source register holds across operations
    always @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            source_operand <= 8'h00;
        end else if (wr_en) begin
            if (ADDR_I == `IMD_ADDR_SRC_LO) begin
                source_operand[3:0] <= WDATA_I;
            end else if (ADDR_I == `IMD_ADDR_SRC_HI) begin
                source_operand[7:4] <= WDATA_I;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // operands latched at start so later writes cannot disturb the result
    always @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            calc_mode_bit <= 1'b0;
            op_mode <= `IMD_MODE_MUL;
            cyc_cnt <= 4'h0;
            op_dest <= 16'h0000;
            op_src <= 8'h00;
            div_load <= 1'b0;
            step_cnt <= 5'h00;
        end else begin
            div_load <= 1'b0;
            if (calc_mode_bit && step_cnt != 5'h00 && !div_load) begin
                step_cnt <= step_cnt - 5'h01;
            end
            if (start) begin
                calc_mode_bit <= 1'b1;
                op_mode <= WDATA_I[`IMD_BIT_CALC_MODE];
                cyc_cnt <= 4'h0;
                op_dest <= {dest_high_byte, dest_low_byte};
                op_src <= source_operand;
                div_load <= 1'b1;
                step_cnt <= DIV_STEPS[4:0];
            end else if (finish) begin
                calc_mode_bit <= 1'b0;
            end else if (calc_mode_bit && tick) begin
                cyc_cnt <= cyc_cnt + 4'h1;
            end
        end
    end

    always @* begin
        next_product = op_dest[7:0] * op_src;
    end

    //////////////////////////////////////////////////////////////////////////
    // destination bytes and flags; completion takes priority over cpu writes
    always @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            dest_low_byte <= 8'h00;
            dest_high_byte <= 8'h00;
            negative_flag <= 1'b0;
            overflow_flag <= 1'b0;
            zero_result_flag <= 1'b0;
        end else if (finish) begin
            if (op_mode == `IMD_MODE_MUL) begin
                dest_low_byte <= next_product[7:0];
                dest_high_byte <= next_product[15:8];
                negative_flag <= next_product[15];
                overflow_flag <= 1'b0;
                zero_result_flag <= (next_product == 16'h0000);
            end else if (div_ovf) begin
                // destination keeps the dividend; overflow set, negative and zero flags reflect its low byte
                negative_flag <= op_dest[7];
                overflow_flag <= 1'b1;
                zero_result_flag <= (op_dest[7:0] == 8'h00);
            end else begin
                // results not otherwise checked by hardware
                dest_low_byte <= quotient[7:0];
                dest_high_byte <= remainder[7:0];
                negative_flag <= quotient[7];
                overflow_flag <= 1'b0;
                zero_result_flag <= (quotient[7:0] == 8'h00);
            end
        end else if (wr_en && !calc_mode_bit) begin
            case (ADDR_I)
                `IMD_ADDR_DL_LO: dest_low_byte[3:0] <= WDATA_I;
                `IMD_ADDR_DL_HI: dest_low_byte[7:4] <= WDATA_I;
                `IMD_ADDR_DH_LO: dest_high_byte[3:0] <= WDATA_I;
                `IMD_ADDR_DH_HI: dest_high_byte[7:4] <= WDATA_I;
                default: dest_low_byte <= dest_low_byte;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // registered read data; unmapped addresses read zero
    always @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            RDATA_O <= 4'h0;
            BUSY_O <= 1'b0;
        end else begin
            BUSY_O <= calc_mode_bit;
            if (RD_I) begin
                case (ADDR_I)
                    `IMD_ADDR_CLK_GATES: RDATA_O <= clk_gates;
                    `IMD_ADDR_SRC_LO: RDATA_O <= source_operand[3:0];
                    `IMD_ADDR_SRC_HI: RDATA_O <= source_operand[7:4];
                    `IMD_ADDR_DL_LO: RDATA_O <= dest_low_byte[3:0];
                    `IMD_ADDR_DL_HI: RDATA_O <= dest_low_byte[7:4];
                    `IMD_ADDR_DH_LO: RDATA_O <= dest_high_byte[3:0];
                    `IMD_ADDR_DH_HI: RDATA_O <= dest_high_byte[7:4];
                    `IMD_ADDR_CTRL: RDATA_O <= {negative_flag, overflow_flag,
                        zero_result_flag, calc_mode_bit};
                    default: RDATA_O <= 4'h0;
                endcase
            end else begin
                RDATA_O <= 4'h0;
            end
        end
    end
endmodule // imd_unit

// >>> imd_defs.vh
// constants for the integer multiply/divide unit
`ifndef IMD_DEFS_VH
`define IMD_DEFS_VH
`define IMD_ADDR_CLK_GATES 16'hff16
`define IMD_ADDR_SRC_LO 16'hff70
`define IMD_ADDR_SRC_HI 16'hff71
`define IMD_ADDR_DL_LO 16'hff72
`define IMD_ADDR_DL_HI 16'hff73
`define IMD_ADDR_DH_LO 16'hff74
`define IMD_ADDR_DH_HI 16'hff75
`define IMD_ADDR_CTRL 16'hff76
`define IMD_BIT_ARITH_CKE 3
`define IMD_BIT_CALC_MODE 0
`define IMD_BIT_ZERO 1
`define IMD_BIT_OVF 2
`define IMD_BIT_NEG 3
`define IMD_GATES_RESET 4'h0
`define IMD_OP_CYCLES 4'ha
`define IMD_MODE_MUL 1'b0
`define IMD_MODE_DIV 1'b1
`endif

// >>> imd_clock_select.v
// cpu operating clock enable selection for the arithmetic unit
`timescale 1ns/1ps
module imd_clock_select (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // oscillator ticks and selection
    input wire low_osc_tick_i,
    input wire high_osc_tick_i,
    input wire high_osc_on_i,
    input wire cpu_clock_switch_i,
    input wire arith_clock_enable_i,
    // resulting one-cycle enable
    output reg tick_o
);
    // clock gate modelled as an enable, so there is only one real clock
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tick_o <= 1'b0;
        end else if (!arith_clock_enable_i) begin
            tick_o <= 1'b0;
        end else if (cpu_clock_switch_i && high_osc_on_i) begin
            tick_o <= high_osc_tick_i;
        end else begin
            tick_o <= low_osc_tick_i;
        end
    end
endmodule // imd_clock_select

// >>> imd_divider.v
// 16 by 8 restoring divider, one quotient bit per step
`timescale 1ns/1ps
module imd_divider (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // control
    input wire load_i,
    input wire step_i,
    input wire [15:0] dividend_i,
    input wire [7:0] divisor_i,
    // results
    output reg [15:0] quotient_o,
    output reg [8:0] remainder_o
);
    wire [9:0] trial;
    assign trial = {remainder_o, quotient_o[15]} - {2'b00, divisor_i};
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            quotient_o <= 16'h0000;
            remainder_o <= 9'h000;
        end else if (load_i) begin
            quotient_o <= dividend_i;
            remainder_o <= 9'h000;
        end else if (step_i) begin
            if (!trial[9]) begin
                remainder_o <= trial[8:0];
                quotient_o <= {quotient_o[14:0], 1'b1};
            end else begin
                remainder_o <= {remainder_o[7:0], quotient_o[15]};
                quotient_o <= {quotient_o[14:0], 1'b0};
            end
        end
    end
endmodule // imd_divider

// >>> imd_unit_asserts.sv
// port assertions for the multiply/divide unit
`timescale 1ns/1ps
module imd_unit_asserts #(
    parameter DIV_STEPS = 16
) (
    // clock and reset
    input wire CLOCK_I,
    input wire RST_I,
    // cpu bus
    input wire [15:0] ADDR_I,
    input wire [3:0] WDATA_I,
    input wire WR_I,
    input wire RD_I,
    input wire [3:0] RDATA_O,
    input wire BUSY_O
);
    reg gate;
    // gate writes are taken on any edge, as the unit's clock gate register takes them
    always @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I)
            gate <= 1'b0;
        else if (WR_I && ADDR_I == 16'hff16)
            gate <= WDATA_I[3];
    end
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);
    ////////////////////////////////////////////////////////////
    AST_START: assert property ($rose(BUSY_O) |->
        $past(WR_I, 2) && $past(ADDR_I, 2) == 16'hff76)
        else $error("busy rose without a mode write");
    AST_GATED: assert property ($rose(BUSY_O) |-> $past(gate, 2))
        else $error("operation started with clock disabled");
    AST_MIN_RUN: assert property ($rose(BUSY_O) |-> BUSY_O[*8])
        else $error("operation ended too early");
    AST_DONE: assert property ($rose(BUSY_O) |-> ##[1:600] !BUSY_O)
        else $error("operation never finished");
    AST_BUSY_RD: assert property ($past(RD_I) &&
        $past(ADDR_I) == 16'hff76 |-> RDATA_O[0] == BUSY_O)
        else $error("mode bit read differs from busy");
    AST_GATE_RD: assert property ($past(RD_I) &&
        $past(ADDR_I) == 16'hff16 |-> RDATA_O[3] == $past(gate))
        else $error("clock enable read back wrong");
    AST_IDLE_RD: assert property (!$past(RD_I) |-> RDATA_O == 4'h0)
        else $error("read data without read");
    AST_UNMAPPED: assert property ($past(RD_I) &&
        $past(ADDR_I) == 16'hff77 |-> RDATA_O == 4'h0)
        else $error("unmapped read not zero");
    C_RUN: cover property ($fell(BUSY_O));
    C_CTRL_RD: cover property ($past(RD_I) && $past(ADDR_I) == 16'hff76);
    C_GATE_OFF: cover property ($fell(gate));
endmodule // imd_unit_asserts
bind imd_unit imd_unit_asserts #(.DIV_STEPS(DIV_STEPS)) i_chk (
    .CLOCK_I(CLOCK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
    .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .BUSY_O(BUSY_O));

// >>> imd_unit_tb.sv
// self-checking bench for the multiply/divide unit
`timescale 1ns/1ps
module imd_unit_tb;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg lo_tick = 1'b0;
    reg hi_tick = 1'b0;
    reg hi_on = 1'b0;
    reg sw = 1'b0;
    reg [15:0] addr = 16'h0000;
    reg [3:0] wdata = 4'h0;
    reg wr = 1'b0;
    reg rd = 1'b0;
    wire [3:0] rdata;
    wire busy;
    integer n_errors = 0;
    integer n_checks = 0;
    integer cyc = 0;
    reg [7:0] per = 8'd4;
    reg [7:0] bcnt = 8'h00;
    reg [7:0] run = 8'h00;
    reg [2:0] pf = 3'b000;
    imd_unit i_dut (.CLOCK_I(clk), .RST_I(rst), .LOW_OSC_TICK_I(lo_tick),
        .HIGH_OSC_TICK_I(hi_tick), .HIGH_OSC_ON_I(hi_on),
        .CPU_CLOCK_SWITCH_I(sw), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .BUSY_O(busy));
    always #25 clk = ~clk;
    // fixed tick spacing lets a write held per cycles meet exactly one tick
    always @(posedge clk) begin
        cyc <= cyc + 1;
        lo_tick <= (cyc % 4 == 0);
        hi_tick <= hi_on && (cyc % 3 == 0);
        if (busy === 1'b1)
            bcnt <= bcnt + 8'd1;
        else if (bcnt != 8'd0) begin
            run <= bcnt;
            bcnt <= 8'd0;
        end
        if (cyc == 20000) begin
            n_errors = n_errors + 1;
            conclude;
        end
    end
    ////////////////////////////////////////////////////////////
    task conclude;
        begin
            $display("checks %0d errors %0d", n_checks, n_errors);
            if (n_errors == 0 && n_checks > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        begin
            n_checks = n_checks + 1;
            if (g !== e) begin
                n_errors = n_errors + 1;
                $display("BAD %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task wr4(input [15:0] a, input [3:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            repeat (per) @(posedge clk);
            wr <= 1'b0;
        end
    endtask
    task rd4(input [15:0] a, input [3:0] e);
        begin
            @(posedge clk);
            addr <= a;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            #1 chk($sformatf("rd %h", a), {4'h0, e}, {4'h0, rdata});
        end
    endtask
    task wr8(input [15:0] a, input [7:0] d);
        begin
            wr4(a, d[3:0]);
            wr4(a + 16'h0001, d[7:4]);
        end
    endtask
    task rd8(input [15:0] a, input [7:0] e);
        begin
            rd4(a, e[3:0]);
            rd4(a + 16'h0001, e[7:4]);
        end
    endtask
    task op(input m, input ws, input [7:0] s, input [7:0] dh,
        input [7:0] dl, input [7:0] eh, input [7:0] el, input [2:0] f);
        begin
            if (ws)
                wr8(16'hff70, s);
            wr8(16'hff72, dl);
            wr8(16'hff74, dh);
            wr4(16'hff76, {3'b000, m});
            rd4(16'hff76, {pf, 1'b1});
            wr4(16'hff72, ~dl[3:0]);
            while (busy !== 1'b0)
                @(posedge clk);
            rd4(16'hff76, {f, 1'b0});
            rd8(16'hff72, el);
            rd8(16'hff74, eh);
            chk("run", 8'd10 * per, run);
            pf = f;
        end
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        wr4(16'hff70, 4'h5);
        rd4(16'hff70, 4'h0);
        rd4(16'hff16, 4'h0);
        rd4(16'hff76, 4'h0);
        wr4(16'hff16, 4'h8);
        rd4(16'hff16, 4'h8);
        rd4(16'hff77, 4'h0);
        op(0, 1, 8'h64, 8'h00, 8'h00, 8'h00, 8'h00, 3'b001);
        op(0, 1, 8'h58, 8'h5a, 8'h64, 8'h22, 8'h60, 3'b000);
        op(0, 1, 8'ha5, 8'hff, 8'hc8, 8'h80, 8'he8, 3'b100);
        op(1, 1, 8'h64, 8'h1a, 8'h16, 8'h4e, 8'h42, 3'b000);
        op(1, 0, 8'h64, 8'h33, 8'h2c, 8'h00, 8'h83, 3'b100);
        op(1, 1, 8'h58, 8'h00, 8'h00, 8'h00, 8'h00, 3'b001);
        op(1, 1, 8'h13, 8'h24, 8'h68, 8'h24, 8'h68, 3'b010);
        op(1, 0, 8'h13, 8'h11, 8'h68, 8'h0a, 8'hea, 3'b100);
        op(1, 1, 8'h00, 8'h12, 8'h34, 8'h12, 8'h34, 3'b010);
        // switch without a running fast oscillator stays on the slow one
        @(posedge clk);
        sw <= 1'b1;
        op(0, 1, 8'h02, 8'h00, 8'h81, 8'h01, 8'h02, 3'b000);
        // one spare cycle so the fast tick pattern is settled
        @(posedge clk);
        hi_on <= 1'b1;
        per = 8'd3;
        @(posedge clk);
        op(0, 1, 8'hff, 8'h00, 8'hff, 8'hfe, 8'h01, 3'b100);
        wr4(16'hff16, 4'h0);
        wr4(16'hff76, 4'h1);
        rd4(16'hff76, {pf, 1'b0});
        // flags and gate nonzero so the reset below has something to clear
        wr4(16'hff16, 4'h8);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd4(16'hff76, 4'h0);
        rd4(16'hff16, 4'h0);
        conclude;
    end
endmodule // imd_unit_tb
